// ===== logic/ocsel_top.sv
// Option select and trip latching for a two-stage overcurrent module
//
// Function
// RL1 - Characteristic select 0 picks definite time and 1 picks inverse time for the low stage.
// RL2 - In definite time the range switches give 0.05-1.00 s, 0.5-10.0 s (10 or 01), 5-100 s.
// RL3 - In inverse time the range switches pick extreme, very, normal or long-time inverse.
// RL4 - With latching off both trip outputs drop when the causing input falls below start.
// RL5 - With latching on both trip outputs hold after the input falls until cleared.
// RL6 - Latched trips clear on step and reset pressed together or on the serial clear command.
// RL7 - Step and reset pressed together also erase the recorded measurement values.
// RL8 - With doubling off the high stage start value is applied unchanged.
// RL9 - With doubling on the high stage start value doubles while the object is energised.
// RL10 - High range select 0 offers 2.5 to 20 times rated current plus infinite.
// RL11 - High range select 1 offers 0.5 to 4 times rated current plus infinite.
// RL12 - The infinite high stage setting blocks that stage so it never starts or trips.
// RL13 - Each stage has its own trip latch, set independently but cleared together by the one common clear.
`timescale 1ns/1ps
`include "ocsel_defines.svh"

module ocsel_top (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire logic                      clk_en,
  // Front panel and serial inputs (asynchronous)
  input  wire logic [7:0]                front_option_switches,
  input  wire logic                      step_btn,
  input  wire logic                      reset_btn,
  input  wire logic                      serial_clear_cmd,
  // Stage logic inputs (same clock)
  input  wire logic                      low_stage_operate,
  input  wire logic                      high_stage_operate,
  input  wire logic                      object_energising,
  input  wire logic [15:0]               high_start_set,
  input  wire logic                      high_start_infinite,
  // Outputs
  output logic                           low_stage_trip,
  output logic                           high_stage_trip,
  output logic                           erase_records,
  output ocsel_pkg::ocsel_low_cfg_s      low_cfg,
  output ocsel_pkg::ocsel_high_cfg_s     high_cfg
);
  import ocsel_pkg::*;

  // =====================================================
  // Input synchronisers
  logic [10:0] sync1_q;
  logic [10:0] sync2_q;
  logic [10:0] sync_in;
  assign sync_in = {serial_clear_cmd, reset_btn, step_btn, front_option_switches};

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 11'h000;
      sync2_q <= 11'h000;
    end else if (clk_en) begin
      sync1_q <= sync_in;
      sync2_q <= sync1_q;
    end
  end

  logic [7:0] sw;
  logic       step_s;
  logic       reset_s;
  logic       ser_s;
  assign sw      = sync2_q[7:0];
  assign step_s  = sync2_q[8];
  assign reset_s = sync2_q[9];
  assign ser_s   = sync2_q[10];

  // =====================================================
  // Clear request detection
  logic both_q;
  logic both_d;
  logic ser_q;
  logic ser_d;
  logic clear_pulse;
  logic erase_pulse;

  always_comb begin
    both_d = step_s & reset_s;
    ser_d  = ser_s;
  end

  assign erase_pulse = both_d & ~both_q;                 // RL7
  assign clear_pulse = erase_pulse | (ser_d & ~ser_q);   // RL6

  // =====================================================
  // Trip latches, one per stage
  logic       high_blocked;
  logic [1:0] act;
  logic [1:0] trip_q;
  logic [1:0] trip_d;
  logic       erase_q;
  logic       erase_d;

  assign high_blocked = high_start_infinite;               // RL12
  assign act = {high_stage_operate & ~high_blocked, low_stage_operate};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_trip
      always_comb begin
        if (act[gi]) begin
          trip_d[gi] = 1'b1;                               // RL13
        end else if (!sw[`OCSEL_SW_LATCH]) begin
          trip_d[gi] = 1'b0;                               // RL4
        end else if (clear_pulse) begin
          trip_d[gi] = 1'b0;                               // RL6
        end else begin
          trip_d[gi] = trip_q[gi];                         // RL5
        end
      end
    end
  endgenerate

  always_comb begin
    erase_d = erase_pulse;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trip_q  <= {2{`OCSEL_TRIP_RST}};
      both_q  <= 1'b0;
      ser_q   <= 1'b0;
      erase_q <= 1'b0;
    end else if (clk_en) begin
      trip_q  <= trip_d;
      both_q  <= both_d;
      ser_q   <= ser_d;
      erase_q <= erase_d;
    end
  end

  assign low_stage_trip  = trip_q[0];
  assign high_stage_trip = trip_q[1];
  assign erase_records   = erase_q;

  // =====================================================
  // Configuration decode
  ocsel_low_cfg_s  low_d;
  ocsel_low_cfg_s  low_q;
  ocsel_high_cfg_s high_d;
  ocsel_high_cfg_s high_q;
  logic [1:0]      rsel;

  assign rsel = {sw[`OCSEL_SW_RANGE_HI], sw[`OCSEL_SW_RANGE_LO]};

  always_comb begin
    low_d = '0;
    low_d.inverse_mode = sw[`OCSEL_SW_CHAR];               // RL1
    case (rsel)
      2'b00: begin
        low_d.dt_range = OCSEL_DT_SHORT;                   // RL2
        low_d.dt_min   = `OCSEL_DT_R0_MIN;
        low_d.dt_max   = `OCSEL_DT_R0_MAX;
      end
      2'b11: begin
        low_d.dt_range = OCSEL_DT_LONG;                    // RL2
        low_d.dt_min   = `OCSEL_DT_R2_MIN;
        low_d.dt_max   = `OCSEL_DT_R2_MAX;
      end
      default: begin
        low_d.dt_range = OCSEL_DT_MID;                     // RL2
        low_d.dt_min   = `OCSEL_DT_R1_MIN;
        low_d.dt_max   = `OCSEL_DT_R1_MAX;
      end
    endcase
    case (rsel)
      2'b00:   low_d.inverse_time_curve = OCSEL_EXT_INV;   // RL3
      2'b01:   low_d.inverse_time_curve = OCSEL_VERY_INV;  // RL3
      2'b10:   low_d.inverse_time_curve = OCSEL_NORM_INV;  // RL3
      default: low_d.inverse_time_curve = OCSEL_LONG_INV;  // RL3
    endcase
  end

  always_comb begin
    high_d = '0;
    high_d.blocked = high_blocked;                         // RL12
    if (sw[`OCSEL_SW_HS_RANGE]) begin
      high_d.hs_min = `OCSEL_HS_R1_MIN;                    // RL11
      high_d.hs_max = `OCSEL_HS_R1_MAX;
    end else begin
      high_d.hs_min = `OCSEL_HS_R0_MIN;                    // RL10
      high_d.hs_max = `OCSEL_HS_R0_MAX;
    end
    if (sw[`OCSEL_SW_DOUBLE] && object_energising) begin
      high_d.doubled   = 1'b1;
      high_d.start_eff = {high_start_set, 1'b0};           // RL9
    end else begin
      high_d.start_eff = {1'b0, high_start_set};           // RL8
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_q  <= '0;
      high_q <= '0;
    end else if (clk_en) begin
      low_q  <= low_d;
      high_q <= high_d;
    end
  end

  assign low_cfg  = low_q;
  assign high_cfg = high_q;

  // =====================================================
  // Checks
  sequence both_press_s;
    clk_en && both_d && !both_q;
  endsequence

  latch_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL5
    clk_en && trip_q[0] && sw[`OCSEL_SW_LATCH] && !clear_pulse |=> trip_q[0])
    else $error("low trip lost while latched");

  no_latch_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL4
    clk_en && !act[1] && !sw[`OCSEL_SW_LATCH] |=> !trip_q[1])
    else $error("high trip held without latching");

  clear_trip_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL6
    clk_en && clear_pulse && !act[0] |=> !trip_q[0])
    else $error("clear did not drop low trip");

  erase_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL7
    both_press_s |=> erase_records)
    else $error("erase not pulsed on combined press");

  blocked_trip_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL12
    clk_en && high_start_infinite && !trip_q[1] |=> !trip_q[1])
    else $error("blocked high stage tripped");

  double_val_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
    clk_en && sw[`OCSEL_SW_DOUBLE] && object_energising
    |=> high_cfg.start_eff == {$past(high_start_set), 1'b0})
    else $error("start value not doubled");

  plain_val_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL8
    clk_en && !sw[`OCSEL_SW_DOUBLE] |=> high_cfg.start_eff == {1'b0, $past(high_start_set)})
    else $error("start value altered");

  hs_range_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
    clk_en && !sw[`OCSEL_SW_HS_RANGE] |=> high_cfg.hs_max == `OCSEL_HS_R0_MAX)
    else $error("wrong high range max");

  char_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL1
    clk_en |=> low_cfg.inverse_mode == $past(sw[`OCSEL_SW_CHAR]))
    else $error("characteristic not followed");

endmodule

// ===== logic/ocsel_defines.svh
// Constants for the overcurrent option select block
`ifndef OCSEL_DEFINES_SVH
`define OCSEL_DEFINES_SVH

// =====================================================
// Switch bit positions within the front switch bank
`define OCSEL_SW_RANGE_LO    0
`define OCSEL_SW_RANGE_HI    1
`define OCSEL_SW_CHAR        2
`define OCSEL_SW_LATCH       3
`define OCSEL_SW_DOUBLE      4
`define OCSEL_SW_HS_RANGE    5

// =====================================================
// Range limits in hundredths (seconds or times rated current)
`define OCSEL_DT_R0_MIN      16'h0005
`define OCSEL_DT_R0_MAX      16'h0064
`define OCSEL_DT_R1_MIN      16'h0032
`define OCSEL_DT_R1_MAX      16'h03E8
`define OCSEL_DT_R2_MIN      16'h01F4
`define OCSEL_DT_R2_MAX      16'h2710
`define OCSEL_HS_R0_MIN      16'h00FA
`define OCSEL_HS_R0_MAX      16'h07D0
`define OCSEL_HS_R1_MIN      16'h0032
`define OCSEL_HS_R1_MAX      16'h0190

// =====================================================
// Reset values
`define OCSEL_TRIP_RST       1'b0
`define OCSEL_SW_RST         8'h00

`endif

// ===== logic/ocsel_pkg.sv
// Types for the overcurrent option select block
package ocsel_pkg;

  typedef enum logic [1:0] {
    OCSEL_DT_SHORT = 2'b00,
    OCSEL_DT_MID   = 2'b01,
    OCSEL_DT_LONG  = 2'b10
  } ocsel_dt_range_e;

  typedef enum logic [1:0] {
    OCSEL_EXT_INV  = 2'b00,
    OCSEL_VERY_INV = 2'b01,
    OCSEL_NORM_INV = 2'b10,
    OCSEL_LONG_INV = 2'b11
  } ocsel_curve_e;

  typedef struct packed {
    logic            inverse_mode;
    ocsel_dt_range_e dt_range;
    ocsel_curve_e    inverse_time_curve;
    logic [15:0]     dt_min;
    logic [15:0]     dt_max;
  } ocsel_low_cfg_s;

  typedef struct packed {
    logic        blocked;
    logic        doubled;
    logic [15:0] hs_min;
    logic [15:0] hs_max;
    logic [16:0] start_eff;
  } ocsel_high_cfg_s;

endpackage

// ===== tb/ocsel_panel_model.sv
// Operator panel model: switch bank, pushbuttons and serial clear source
`timescale 1ns/1ps

module ocsel_panel_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Operator requests from the bench
  input  wire logic [7:0] sw_req,
  input  wire logic       press_req,
  input  wire logic       clear_req,
  // Panel lines towards the block
  output logic [7:0]      front_option_switches,
  output logic            step_btn,
  output logic            reset_btn,
  output logic            serial_clear_cmd
);
  // ==========================================
  // Panel lines change just after each edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      front_option_switches <= 8'h00;
      step_btn              <= 1'h0;
      reset_btn             <= 1'h0;
      serial_clear_cmd      <= 1'h0;
    end else begin
      front_option_switches <= sw_req;
      step_btn              <= press_req;
      reset_btn             <= press_req;
      serial_clear_cmd      <= clear_req;
    end
  end
endmodule

// ===== tb/test_ocsel_top.sv
// Self-checking bench for the overcurrent option select block
`timescale 1ns/1ps
`include "ocsel_defines.svh"

module test_ocsel_top;
  import ocsel_pkg::*;
  // ==========================================
  // Stimulus and observation
  logic            ref_clk = 1'h0;
  logic            rst_b   = 1'h0;
  logic            clk_en  = 1'h1;
  logic [7:0]      sw_req  = 8'h00;
  logic            press_req = 1'h0;
  logic            clear_req = 1'h0;
  logic            lo_op = 1'h0;
  logic            hi_op = 1'h0;
  logic            energ = 1'h0;
  logic            inf   = 1'h0;
  logic [15:0]     hs_set = 16'h0000;
  logic [7:0]      sw;
  logic            step_b, rst_btn, sclr, lo_trip, hi_trip, erase;
  ocsel_low_cfg_s  low_cfg;
  ocsel_high_cfg_s high_cfg;
  int              error_cnt = 0;
  int              n_tests = 0;
  int              erase_seen = 0;

  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (erase === 1'h1) erase_seen++;

  ocsel_panel_model u_panel (.ref_clk(ref_clk), .rst_b(rst_b), .sw_req(sw_req),
    .press_req(press_req), .clear_req(clear_req), .front_option_switches(sw),
    .step_btn(step_b), .reset_btn(rst_btn), .serial_clear_cmd(sclr));

  ocsel_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .front_option_switches(sw), .step_btn(step_b), .reset_btn(rst_btn),
    .serial_clear_cmd(sclr), .low_stage_operate(lo_op), .high_stage_operate(hi_op),
    .object_energising(energ), .high_start_set(hs_set), .high_start_infinite(inf),
    .low_stage_trip(lo_trip), .high_stage_trip(hi_trip), .erase_records(erase),
    .low_cfg(low_cfg), .high_cfg(high_cfg));

  // ==========================================
  // Access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic settle(input int n);
    tick(n);
    @(negedge ref_clk);
  endtask
  task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic drive(input logic [7:0] v, input logic lo, input logic hi,
                       input logic en, input logic in, input logic [15:0] s, input int n);
    tick(1);
    sw_req <= v;
    lo_op  <= lo;
    hi_op  <= hi;
    energ  <= en;
    inf    <= in;
    hs_set <= s;
    settle(n);
  endtask
  task automatic pulse(input logic both);
    tick(1);
    if (both) press_req <= 1'h1;
    else clear_req <= 1'h1;
    tick(6);
    press_req <= 1'h0;
    clear_req <= 1'h0;
    settle(6);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(25 * 3000);
    error_cnt++;
    wrap_up();
  end

  // ==========================================
  // Tests
  initial begin
    logic [3:0]  k;
    logic [1:0]  r;
    logic        dbl;
    logic [15:0] s;
    tick(12);
    rst_b <= 1'h1;
    tick(2);
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      r = k[1:0];
      dbl = k[0] & k[1];
      s = 16'h0123 + 16'(i);
      drive({2'h0, k[3], k[0], 1'h0, k[2:0]}, 1'h0, 1'h0, k[1], 1'h0, s, 8);
      chk("inverse_mode", 17'(k[2]), 17'(low_cfg.inverse_mode));
      if (!k[2]) begin
        chk("dt_range", 17'(r == 2'h0 ? OCSEL_DT_SHORT : r == 2'h3 ? OCSEL_DT_LONG :
            OCSEL_DT_MID), 17'(low_cfg.dt_range));
        chk("dt_min", 17'(r == 2'h0 ? `OCSEL_DT_R0_MIN : r == 2'h3 ? `OCSEL_DT_R2_MIN :
            `OCSEL_DT_R1_MIN), 17'(low_cfg.dt_min));
        chk("dt_max", 17'(r == 2'h0 ? `OCSEL_DT_R0_MAX : r == 2'h3 ? `OCSEL_DT_R2_MAX :
            `OCSEL_DT_R1_MAX), 17'(low_cfg.dt_max));
      end else begin
        chk("curve", 17'(r), 17'(low_cfg.inverse_time_curve));
      end
      chk("hs_min", 17'(k[3] ? `OCSEL_HS_R1_MIN : `OCSEL_HS_R0_MIN), 17'(high_cfg.hs_min));
      chk("hs_max", 17'(k[3] ? `OCSEL_HS_R1_MAX : `OCSEL_HS_R0_MAX), 17'(high_cfg.hs_max));
      chk("doubled", 17'(dbl), 17'(high_cfg.doubled));
      chk("start_eff", dbl ? {s, 1'h0} : {1'h0, s}, high_cfg.start_eff);
      chk("blocked", 17'h00000, 17'(high_cfg.blocked));
    end
    $display("test decode done");
    drive(8'h00, 1'h0, 1'h1, 1'h0, 1'h1, 16'h0100, 3);
    chk("blocked", 17'h00001, 17'(high_cfg.blocked));
    chk("high_trip", 17'h00000, 17'(hi_trip));
    $display("test infinite done");
    drive(8'h00, 1'h1, 1'h1, 1'h0, 1'h0, 16'h0100, 3);
    chk("low_trip", 17'h00001, 17'(lo_trip));
    chk("high_trip", 17'h00001, 17'(hi_trip));
    drive(8'h00, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0100, 3);
    chk("low_trip", 17'h00000, 17'(lo_trip));
    chk("high_trip", 17'h00000, 17'(hi_trip));
    $display("test self reset done");
    tick(1);
    clk_en <= 1'h0;
    drive(8'h00, 1'h1, 1'h0, 1'h0, 1'h0, 16'h0200, 3);
    chk("frozen_trip", 17'h00000, 17'(lo_trip));
    chk("frozen_start", 17'h00100, high_cfg.start_eff);
    drive(8'h00, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0100, 1);
    tick(1);
    clk_en <= 1'h1;
    settle(2);
    chk("low_trip", 17'h00000, 17'(lo_trip));
    chk("start_eff", 17'h00100, high_cfg.start_eff);
    $display("test clock enable done");
    drive(8'h08, 1'h1, 1'h0, 1'h0, 1'h0, 16'h0100, 8);
    drive(8'h08, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0100, 3);
    chk("low_trip", 17'h00001, 17'(lo_trip));
    chk("high_trip", 17'h00000, 17'(hi_trip));
    drive(8'h08, 1'h0, 1'h1, 1'h0, 1'h0, 16'h0100, 3);
    drive(8'h08, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0100, 3);
    chk("high_trip", 17'h00001, 17'(hi_trip));
    erase_seen = 0;
    pulse(1'h1);
    chk("low_trip", 17'h00000, 17'(lo_trip));
    chk("high_trip", 17'h00000, 17'(hi_trip));
    chk("erase_pulses", 17'h00001, 17'(erase_seen));
    drive(8'h08, 1'h1, 1'h0, 1'h0, 1'h0, 16'h0100, 3);
    drive(8'h08, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0100, 3);
    erase_seen = 0;
    pulse(1'h0);
    chk("low_trip", 17'h00000, 17'(lo_trip));
    chk("erase_pulses", 17'h00000, 17'(erase_seen));
    $display("test latching done");
    wrap_up();
  end
endmodule
